// ===== bus_model.sv
`timescale 1ns/1ns

// ****************************************************************
// target bus and event comparator model
// ****************************************************************
module bus_model
    import trace_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // bench control
    input wire logic emit,
    input wire logic [2:0] kind,
    input wire logic [EVENTS-1:0] hit_mask,
    input wire logic [15:0] hit_at,
    // target bus cycle
    output logic cyc_valid,
    output logic [ADDR_W-1:0] cyc_addr,
    output logic [DATA_W-1:0] cyc_data,
    output logic cyc_write,
    output logic [2:0] cyc_type,
    output logic [EXTRA_W-1:0] cyc_extra,
    // comparator hits
    output logic [EVENTS-1:0] event_hit
);
    logic [16:0] k_q;

    // one cycle per clock; the bus never waits for ready
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            k_q <= '0;
            cyc_valid <= 1'b0;
            cyc_addr <= '0;
            cyc_data <= '0;
            cyc_write <= 1'b0;
            cyc_type <= '0;
            cyc_extra <= '0;
            event_hit <= '0;
        end else if (emit) begin
            cyc_valid <= 1'b1;
            cyc_addr <= 24'h40_0000 + ADDR_W'(k_q);
            cyc_data <= k_q[15:0] ^ 16'hA5A5;
            cyc_write <= k_q[0];
            cyc_type <= kind;
            cyc_extra <= 23'h5A_0000 | EXTRA_W'(k_q);
            event_hit <= (k_q[15:0] == hit_at) ? hit_mask : '0;
            k_q <= k_q + 17'h0_0001;
        end else begin
            // idle bus shows a changing pattern, not the last cycle
            cyc_valid <= 1'b0;
            cyc_addr <= ~cyc_addr;
            cyc_data <= ~cyc_data;
            cyc_write <= ~cyc_write;
            cyc_type <= ~cyc_type;
            cyc_extra <= ~cyc_extra;
            event_hit <= '0;
            k_q <= '0;
        end
    end
endmodule : bus_model

// ===== trace_capture.sv
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/1ns

// ********************************************************************
// record fifo
// ********************************************************************
module trace_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0] rd_q;
    logic [PW-1:0] wr_q;
    logic [PW:0] cnt_q;
    logic [PW:0] cnt_d;
    logic push;
    logic pop;

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_q[rd_q];

    always_comb begin
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
            rd_q <= '0;
            wr_q <= '0;
            in_ready <= 1'b1;
            out_valid <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            rd_q <= pop ? rd_q + 1'b1 : rd_q;
            wr_q <= push ? wr_q + 1'b1 : wr_q;
            in_ready <= (cnt_d != (PW+1)'(DEPTH));
            out_valid <= (cnt_d != '0);
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end
endmodule : trace_fifo

module trace_capture
    import trace_pkg::*;
(
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // target bus cycle
    input wire logic cyc_valid,
    input wire logic [ADDR_W-1:0] cyc_addr,
    input wire logic [DATA_W-1:0] cyc_data,
    input wire logic cyc_write,
    input wire logic [2:0] cyc_type,
    input wire logic [EXTRA_W-1:0] cyc_extra,
    output logic cyc_ready,
    // run state and event points
    input wire logic prog_run,
    input wire logic [EVENTS-1:0] event_hit,
    // capture state
    output logic capturing
);
    // ****************************************************************
    // registers
    // ****************************************************************
    logic [31:0] ctrl_q;
    logic [EVENTS-1:0] imm_mask_q;
    logic [EVENTS-1:0] dly_mask_q;
    logic [EVENTS-1:0] start_mask_q;
    logic [EVENTS-1:0] evt_valid_q;
    logic [DLY_W-1:0] dly_count_q;
    logic [IDX_W-1:0] rd_index_q;
    logic [IDX_W-1:0] record_index_q;
    logic wrapped_q;
    logic [TS_W-1:0] ts_q;
    logic [ACC_W-1:0] acc_q;
    logic run_q;
    logic dly_arm_q;
    logic [DLY_W-1:0] dly_cnt_q;
    logic [REC_W-1:0] buf_q [RECORDS];

    logic [3:0] res;
    logic run_start;
    logic setup;
    logic wr_en;
    logic rec_rd;
    logic ts_tick;
    logic supp;
    logic imm_fire;
    logic dly_fire;
    logic start_hit;
    logic push;
    logic dly_done;
    logic cap_d;
    logic [REC_W-1:0] rec;
    logic f_valid;
    logic f_ready;
    logic [REC_W-1:0] f_data;
    logic [REC_W-1:0] rd_rec;

    function automatic logic mask_live(input logic [EVENTS-1:0] m,
                                       input logic [EVENTS-1:0] v);
        mask_live = (m != '0) && ((m & ~v) == '0);
    endfunction : mask_live

    assign res = ctrl_q[CTRL_RES_LSB +: 4];
    assign run_start = prog_run && !run_q;
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pready && pwrite;
    assign rec_rd = psel && !pwrite && (paddr >= OFS_RD_ADDR)
                    && (paddr <= OFS_RD_EXTRA);
    assign rd_rec = buf_q[rd_index_q];

    // ****************************************************************
    // apb slave
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= CTRL_RESET;
            imm_mask_q <= '0;
            dly_mask_q <= '0;
            start_mask_q <= '0;
            evt_valid_q <= '0;
            dly_count_q <= DLY_COUNT_RESET;
            rd_index_q <= '0;
        end else if (wr_en) begin
            case (paddr)
                OFS_CTRL: ctrl_q <= pwdata & 32'h0000_0F1F;
                OFS_IMM_MASK: imm_mask_q <= pwdata[EVENTS-1:0];
                OFS_DLY_MASK: dly_mask_q <= pwdata[EVENTS-1:0];
                OFS_START_MASK: start_mask_q <= pwdata[EVENTS-1:0];
                OFS_EVT_VALID: evt_valid_q <= pwdata[EVENTS-1:0];
                OFS_DLY_COUNT: dly_count_q <= pwdata[DLY_W-1:0];
                OFS_RD_INDEX: rd_index_q <= pwdata[IDX_W-1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup;
            pslverr <= 1'b0;
            if (setup) begin
                prdata <= '0;
                case (paddr)
                    OFS_CTRL: prdata <= ctrl_q;
                    OFS_IMM_MASK: prdata <= 32'(imm_mask_q);
                    OFS_DLY_MASK: prdata <= 32'(dly_mask_q);
                    OFS_START_MASK: prdata <= 32'(start_mask_q);
                    OFS_EVT_VALID: prdata <= 32'(evt_valid_q);
                    OFS_DLY_COUNT: prdata <= 32'(dly_count_q);
                    OFS_STATUS: prdata <= {29'h0, dly_arm_q, wrapped_q,
                                           capturing};
                    OFS_WR_INDEX: prdata <= 32'(record_index_q);
                    OFS_TSTAMP: prdata <= ts_q;
                    OFS_RD_INDEX: prdata <= 32'(rd_index_q);
                    OFS_RD_ADDR: prdata <= {7'h0, rd_rec[TS_W],
                                            rd_rec[REC_W-1 -: ADDR_W]};
                    OFS_RD_DATA: prdata <= 32'(rd_rec[TS_W+1 +: DATA_W]);
                    OFS_RD_EXTRA: prdata <= rd_rec[TS_W-1:0];
                    default: pslverr <= 1'b1;
                endcase
            end
        end
    end

    // ****************************************************************
    // timestamp
    // ****************************************************************
    // fractional accumulator keeps 125 ns exact on a 20 ns clock
    assign ts_tick = (res != 4'h0) && (res <= 4'h9)
                     && (acc_q + ACC_W'(CLK_PERIOD_NS) >= ts_period_ns(res));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_q <= '0;
            ts_q <= '0;
            run_q <= 1'b0;
        end else begin
            run_q <= prog_run;
            if (run_start || !ts_tick) begin
                acc_q <= run_start ? '0 : acc_q + ACC_W'(CLK_PERIOD_NS);
            end else begin
                acc_q <= acc_q + ACC_W'(CLK_PERIOD_NS) - ts_period_ns(res);
            end
            if (run_start) begin
                ts_q <= '0;
            end else if (ts_tick) begin
                ts_q <= ts_q + 1'b1;
            end
        end
    end

    // ****************************************************************
    // capture control
    // ****************************************************************
    assign supp = (ctrl_q[CTRL_SUPP_DMA] && cyc_type == CYC_DMA)
                  || (ctrl_q[CTRL_SUPP_REF] && cyc_type == CYC_REFRESH);
    assign imm_fire = ctrl_q[CTRL_IMM_EN]
                      && mask_live(imm_mask_q, evt_valid_q)
                      && ((imm_mask_q & event_hit) != '0);
    assign dly_fire = ctrl_q[CTRL_DLY_EN] && !dly_arm_q && capturing
                      && mask_live(dly_mask_q, evt_valid_q)
                      && ((dly_mask_q & event_hit) != '0);
    assign start_hit = ctrl_q[CTRL_FREE] ? run_start
                       : (mask_live(start_mask_q, evt_valid_q)
                          && ((start_mask_q & event_hit) != '0));
    assign push = cyc_valid && capturing && !supp && cyc_ready && !imm_fire;
    assign dly_done = dly_arm_q && push && (dly_cnt_q <= 16'h0001);

    assign cap_d = prog_run && !imm_fire && !dly_done
                   && (capturing || start_hit);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capturing <= 1'b0;
            dly_arm_q <= 1'b0;
            dly_cnt_q <= '0;
        end else begin
            capturing <= cap_d;
            if (run_start || dly_done || !prog_run) begin
                dly_arm_q <= 1'b0;
            end else if (dly_fire) begin
                dly_arm_q <= 1'b1;
                dly_cnt_q <= dly_count_q;
            end else if (dly_arm_q && push) begin
                dly_cnt_q <= dly_cnt_q - 1'b1;
            end
        end
    end

    // ****************************************************************
    // record assembly and fifo
    // ****************************************************************
    assign rec = {cyc_addr, cyc_data, cyc_write,
                  (ts_period_ns(res) != '0) ? ts_q : TS_W'(cyc_extra)};

    trace_fifo #(
        .WIDTH(REC_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(pclk),
        .rst_n(presetn),
        .in_valid(push),
        .in_ready(cyc_ready),
        .in_data(rec),
        .out_valid(f_valid),
        .out_ready(f_ready),
        .out_data(f_data)
    );

    // record readout by software holds the drain
    assign f_ready = !rec_rd;

    // ****************************************************************
    // trace buffer
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            record_index_q <= '0;
            wrapped_q <= 1'b0;
        end else if (run_start) begin
            record_index_q <= '0;
            wrapped_q <= 1'b0;
        end else if (f_valid && f_ready) begin
            record_index_q <= record_index_q + 1'b1;
            if (record_index_q == IDX_W'(RECORDS - 1)) begin
                wrapped_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge pclk) begin
        if (f_valid && f_ready) begin
            buf_q[record_index_q] <= f_data;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking chk_clk @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_wrap;
        f_valid && f_ready && !run_start
            && record_index_q == IDX_W'(RECORDS - 1)
        |=> record_index_q == '0 && wrapped_q;
    endproperty
    a_wrap: assert property (p_wrap) else $error("index did not wrap");
    property p_supp;
        cyc_valid && ctrl_q[CTRL_SUPP_DMA] && cyc_type == CYC_DMA |-> !push;
    endproperty
    a_supp: assert property (p_supp) else $error("dma cycle stored");
    property p_ts_inc;
        ts_tick && !run_start |=> ts_q == $past(ts_q) + 1'b1;
    endproperty
    a_ts_inc: assert property (p_ts_inc) else $error("tick lost");
    property p_ts_off;
        res == 4'h0 && !run_start |=> $stable(ts_q);
    endproperty
    a_ts_off: assert property (p_ts_off) else $error("ts moved");
    property p_ts_rate;
        res == 4'h4 && $stable(res) [*8] ##1 ts_tick |-> !$past(ts_tick);
    endproperty
    a_ts_rate: assert property (p_ts_rate) else $error("1 us rate");
    property p_free_start;
        ctrl_q[CTRL_FREE] && run_start && !imm_fire |=> capturing;
    endproperty
    a_free_start: assert property (p_free_start) else $error("no start");
    property p_restart;
        run_start |=> ts_q == '0 && record_index_q == '0;
    endproperty
    a_restart: assert property (p_restart) else $error("no restart");
    property p_imm;
        imm_fire |-> !push ##1 !capturing;
    endproperty
    a_imm: assert property (p_imm) else $error("imm halt late");
    property p_halt;
        !prog_run |=> !capturing;
    endproperty
    a_halt: assert property (p_halt) else $error("capture past halt");
    property p_dly;
        dly_done |=> !capturing && !dly_arm_q;
    endproperty
    a_dly: assert property (p_dly) else $error("delay halt");
    property p_imm_off;
        !ctrl_q[CTRL_IMM_EN] |-> !imm_fire;
    endproperty
    a_imm_off: assert property (p_imm_off) else $error("imm off");
    c_wrap: cover property ($rose(wrapped_q));
    c_imm: cover property (capturing && imm_fire);
    c_dly: cover property (dly_fire ##[1:40] dly_done);
endmodule : trace_capture

// ===== trace_capture_tb.sv
`timescale 1ns/1ns

module trace_capture_tb
    import trace_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready, pslverr, serr, chained, saw_full;
    logic cyc_valid, cyc_write, cyc_ready, capturing;
    logic [ADDR_W-1:0] cyc_addr;
    logic [DATA_W-1:0] cyc_data;
    logic [2:0] cyc_type;
    logic [EXTRA_W-1:0] cyc_extra;
    logic prog_run = 1'b0;
    logic emit = 1'b0;
    logic [2:0] kind = '0;
    logic [EVENTS-1:0] hit_mask = '0, tb_hit = '0, model_hit, ev_all;
    int err_total = 0;
    int total_checks = 0;
    int per [9] = '{125, 250, 500, 1000, 2000, 4000, 8000, 16000, 100000};

    assign ev_all = model_hit | tb_hit;
    always #10 pclk = ~pclk;
    initial chained = 1'b0;
    initial saw_full = 1'b0;
    always @(posedge pclk) if (cyc_ready === 1'b0) saw_full <= 1'b1;

    trace_capture trace_capture_inst(.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cyc_valid(cyc_valid), .cyc_addr(cyc_addr),
        .cyc_data(cyc_data), .cyc_write(cyc_write), .cyc_type(cyc_type),
        .cyc_extra(cyc_extra), .cyc_ready(cyc_ready),
        .prog_run(prog_run), .event_hit(ev_all), .capturing(capturing));

    bus_model bus_model_inst(.pclk(pclk), .presetn(presetn), .emit(emit),
        .kind(kind), .hit_mask(hit_mask), .hit_at(16'h0005),
        .cyc_valid(cyc_valid), .cyc_addr(cyc_addr), .cyc_data(cyc_data),
        .cyc_write(cyc_write), .cyc_type(cyc_type), .cyc_extra(cyc_extra),
        .event_hit(model_hit));

    // ****************************************************************
    // apb master and compare tasks
    // ****************************************************************
    task automatic check_eq(input logic [31:0] got, input logic [31:0] exp,
        input string m);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : check_eq

    task automatic check_range(input logic [31:0] got,
        input logic [31:0] lo, input logic [31:0] hi, input string m);
        total_checks++;
        if ($isunknown(got) || got < lo || got > hi) begin
            err_total++;
            $display("[FAIL] %0t %s got %0d", $time, m, got);
        end
    endtask : check_range

    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] wd, output logic [31:0] rd, input logic keep);
        int n;
        if (!chained) @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) check_eq(32'h0000_0000, 32'h0000_0001, "no pready");
        rd = prdata;
        serr = pslverr;
        if (!keep) begin
            psel <= 1'b0;
            penable <= 1'b0;
        end
        chained = keep;
    endtask : apb

    task automatic apb_wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        apb(1'b1, a, d, rd, 1'b0);
    endtask : apb_wr

    task automatic apb_rd(input logic [7:0] a, output logic [31:0] rd);
        apb(1'b0, a, 32'h0000_0000, rd, 1'b0);
    endtask : apb_rd

    task automatic chk_rec(input logic [31:0] idx, input logic [31:0] w0,
        input logic [31:0] w1, input logic [31:0] w2);
        logic [31:0] rd;
        apb_wr(OFS_RD_INDEX, idx);
        apb_rd(OFS_RD_ADDR, rd);
        check_eq(rd, w0, "record address");
        apb_rd(OFS_RD_DATA, rd);
        check_eq(rd, w1, "record data");
        apb_rd(OFS_RD_EXTRA, rd);
        check_eq(rd, w2, "record stamp or extra");
    endtask : chk_rec

    // one program run with the bus emitting n cycles
    task automatic run_case(input logic [31:0] ctrl, input logic [11:0] imm,
        input logic [11:0] hit, input logic [2:0] kd, input logic start,
        input int n, input logic [31:0] exp);
        logic [31:0] rd;
        apb_wr(OFS_CTRL, ctrl);
        apb_wr(OFS_IMM_MASK, {20'h0_0000, imm});
        @(posedge pclk);
        prog_run <= 1'b1;
        hit_mask <= hit;
        kind <= kd;
        @(posedge pclk);
        tb_hit <= {11'h000, start};
        @(posedge pclk);
        tb_hit <= '0;
        emit <= 1'b1;
        repeat (n) @(posedge pclk);
        emit <= 1'b0;
        repeat (6) @(posedge pclk);
        apb_rd(OFS_WR_INDEX, rd);
        check_eq(rd, exp, "records written");
        prog_run <= 1'b0;
        repeat (3) @(posedge pclk);
        check_eq({31'h0, capturing}, 32'h0000_0000, "capture after halt");
    endtask : run_case

    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : conclude

    initial begin
        repeat (80000) @(posedge pclk);
        err_total++;
        $display("[FAIL] %0t watchdog expired", $time);
        conclude();
    end

    // ****************************************************************
    // tests
    // ****************************************************************
    initial begin
        logic [31:0] rd;
        logic [31:0] ex;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb_rd(OFS_CTRL, rd);
        check_eq(rd, CTRL_RESET, "ctrl reset");
        apb_rd(OFS_DLY_COUNT, rd);
        check_eq(rd, {16'h0000, DLY_COUNT_RESET}, "count reset");
        apb_rd(8'h3C, rd);
        check_eq(rd, 32'h0000_0000, "unmapped read");
        check_eq({31'h0, serr}, 32'h0000_0001, "unmapped error");
        apb_wr(OFS_EVT_VALID, 32'h0000_0007);
        apb_wr(OFS_START_MASK, 32'h0000_0001);
        apb_wr(OFS_DLY_MASK, 32'h0000_0004);
        apb_wr(OFS_DLY_COUNT, 32'h0000_0003);
        run_case(32'h0000_0001, 12'h000, 12'h000, 3'h0, 1'b0, 12, 12);
        chk_rec(3, 32'h0140_0003, 32'h0000_A5A6, 32'h005A_0003);
        run_case(32'h0000_0000, 12'h000, 12'h000, 3'h0, 1'b0, 12, 0);
        run_case(32'h0000_0008, 12'h002, 12'h002, 3'h0, 1'b1, 12, 5);
        run_case(32'h0000_0000, 12'h002, 12'h002, 3'h0, 1'b1, 12, 12);
        run_case(32'h0000_0009, 12'h002, 12'h002, 3'h0, 1'b0, 12, 5);
        run_case(32'h0000_0018, 12'h002, 12'h004, 3'h0, 1'b1, 12, 9);
        run_case(32'h0000_0008, 12'h00A, 12'h002, 3'h0, 1'b1, 12, 12);
        run_case(32'h0000_0003, 12'h000, 12'h000, CYC_DMA, 1'b0, 12, 0);
        run_case(32'h0000_0005, 12'h000, 12'h000, CYC_REFRESH, 1'b0, 12, 0);
        run_case(32'h0000_0003, 12'h000, 12'h000, CYC_REFRESH, 1'b0, 12, 12);
        run_case(32'h0000_0401, 12'h000, 12'h000, 3'h0, 1'b0, 12, 12);
        chk_rec(3, 32'h0140_0003, 32'h0000_A5A6, 32'h0000_0000);
        for (int r = 1; r <= 9; r++) begin
            apb_wr(OFS_CTRL, 32'h0000_0001 | (r << CTRL_RES_LSB));
            prog_run <= 1'b1;
            repeat (500) @(posedge pclk);
            apb_rd(OFS_TSTAMP, rd);
            ex = 10020 / per[r-1];
            check_range(rd, (ex > 0) ? ex - 1 : 0, ex + 1, "stamp");
            prog_run <= 1'b0;
            repeat (3) @(posedge pclk);
        end
        run_case(32'h0000_0001, 12'h000, 12'h000, 3'h0, 1'b0, 32770, 2);
        apb_rd(OFS_STATUS, rd);
        check_eq(rd, 32'h0000_0002, "wrapped status");
        chk_rec(0, 32'h0040_8000, 32'h0000_25A5, 32'h005A_8000);
        chk_rec(2, 32'h0040_0002, 32'h0000_A5A7, 32'h005A_0002);
        apb_wr(OFS_CTRL, 32'h0000_0001);
        prog_run <= 1'b1;
        fork
            for (int i = 0; i < 24; i++) apb(1'b0, OFS_RD_ADDR, 0, rd, i < 23);
            begin
                repeat (2) @(posedge pclk);
                emit <= 1'b1;
                repeat (40) @(posedge pclk);
                emit <= 1'b0;
            end
        join
        repeat (40) @(posedge pclk);
        check_eq({31'h0, saw_full}, 32'h0000_0001, "fifo refused");
        check_eq({31'h0, cyc_ready}, 32'h0000_0001, "fifo drained");
        apb_rd(OFS_WR_INDEX, rd);
        check_range(rd, 32, 39, "stalled drain count");
        prog_run <= 1'b0;
        repeat (3) @(posedge pclk);
        conclude();
    end
endmodule : trace_capture_tb

// ===== trace_pkg.sv
package trace_pkg;

    // ****************************************************************
    // sizes
    // ****************************************************************
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam int TS_W = 32;
    localparam int EXTRA_W = 23;
    localparam int REC_W = ADDR_W + DATA_W + 1 + TS_W;
    localparam int RECORDS = 32768;
    localparam int IDX_W = 15;
    localparam int EVENTS = 12;
    localparam int FIFO_DEPTH = 32;
    localparam int DLY_W = 16;

    // ****************************************************************
    // apb register offsets
    // ****************************************************************
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_IMM_MASK = 8'h04;
    localparam logic [7:0] OFS_DLY_MASK = 8'h08;
    localparam logic [7:0] OFS_DLY_COUNT = 8'h0C;
    localparam logic [7:0] OFS_EVT_VALID = 8'h10;
    localparam logic [7:0] OFS_START_MASK = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam logic [7:0] OFS_WR_INDEX = 8'h1C;
    localparam logic [7:0] OFS_TSTAMP = 8'h20;
    localparam logic [7:0] OFS_RD_INDEX = 8'h24;
    localparam logic [7:0] OFS_RD_ADDR = 8'h28;
    localparam logic [7:0] OFS_RD_DATA = 8'h2C;
    localparam logic [7:0] OFS_RD_EXTRA = 8'h30;

    // ****************************************************************
    // control fields
    // ****************************************************************
    localparam int CTRL_FREE = 0;
    localparam int CTRL_SUPP_DMA = 1;
    localparam int CTRL_SUPP_REF = 2;
    localparam int CTRL_IMM_EN = 3;
    localparam int CTRL_DLY_EN = 4;
    localparam int CTRL_RES_LSB = 8;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
    localparam logic [DLY_W-1:0] DLY_COUNT_RESET = 16'h0001;

    // ****************************************************************
    // bus cycle types
    // ****************************************************************
    localparam logic [2:0] CYC_DMA = 3'h3;
    localparam logic [2:0] CYC_REFRESH = 3'h4;

    // ****************************************************************
    // timestamp
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 20;
    localparam int ACC_W = 17;

    function automatic logic [ACC_W-1:0] ts_period_ns(input logic [3:0] r);
        case (r)
            4'h1: ts_period_ns = 17'd125;
            4'h2: ts_period_ns = 17'd250;
            4'h3: ts_period_ns = 17'd500;
            4'h4: ts_period_ns = 17'd1000;
            4'h5: ts_period_ns = 17'd2000;
            4'h6: ts_period_ns = 17'd4000;
            4'h7: ts_period_ns = 17'd8000;
            4'h8: ts_period_ns = 17'd16000;
            4'h9: ts_period_ns = 17'd100000;
            default: ts_period_ns = 17'd0;
        endcase
    endfunction : ts_period_ns

endpackage : trace_pkg
